// file: core/srlsr_pkg.sv
// Operation
// - writing 0x00 to power register powers interface
// - identifier registers must equal transmitter identifiers
// - count fields hold desired value minus one
// - version field 1 selects B, 0 A
// - per-link registers banked by link select bit
// - power and idle-lane registers shared across links
// - lane mask enables receive lanes of link
// - clock_recovery half-rate bit 5, oversample bit 1
// - clock_recovery reset while 0x00, released by 0x01
// - pll divide bits 1:0, bit 2 written one
// - pll enable 0x01 starts, lock bit reads one
package srlsr_pkg;
    // serial control frame: one direction bit, address, one data byte
    localparam int ADDR_W     = 15;
    localparam int DATA_W     = 8;
    localparam int INSTR_BITS = 16;
    localparam int FRAME_BITS = 24;
    localparam int RW_BIT     = 15;
    localparam int LINKS      = 2;
    localparam int LANES      = 8;

    // register offsets
    localparam logic [14:0] OFS_SERIAL_IF_POWER   = 15'h0200;
    localparam logic [14:0] OFS_UNUSED_LANE_MASK  = 15'h0201;
    localparam logic [14:0] OFS_CDR_RESET_CTRL    = 15'h0206;
    localparam logic [14:0] OFS_CDR_RATE_CONFIG   = 15'h0230;
    localparam logic [14:0] OFS_EQUALISER_CONFIG  = 15'h0268;
    localparam logic [14:0] OFS_SERDES_PLL_ENABLE = 15'h0280;
    localparam logic [14:0] OFS_SERDES_PLL_LOCK   = 15'h0281;
    localparam logic [14:0] OFS_SERDES_PLL_DIV    = 15'h0289;
    localparam logic [14:0] OFS_PHY_AUTOTUNE_A    = 15'h02A7;
    localparam logic [14:0] OFS_TERM_A_LOW        = 15'h02AA;
    localparam logic [14:0] OFS_TERM_A_HIGH       = 15'h02AB;
    localparam logic [14:0] OFS_PHY_AUTOTUNE_B    = 15'h02AE;
    localparam logic [14:0] OFS_TERM_B_LOW        = 15'h02B1;
    localparam logic [14:0] OFS_TERM_B_HIGH       = 15'h02B2;
    localparam logic [14:0] OFS_LINK_CONTROL      = 15'h0300;
    localparam logic [14:0] OFS_SERDES_PORT_CFG   = 15'h0314;
    localparam logic [14:0] OFS_DEVICE_IDENT      = 15'h0450;
    localparam logic [14:0] OFS_BANK_IDENT        = 15'h0451;
    localparam logic [14:0] OFS_LANE_IDENT        = 15'h0452;
    localparam logic [14:0] OFS_SCRAMBLE_LANES    = 15'h0453;
    localparam logic [14:0] OFS_OCTETS_PER_FRAME  = 15'h0454;
    localparam logic [14:0] OFS_FRAMES_PER_MF     = 15'h0455;
    localparam logic [14:0] OFS_CONVERTER_COUNT   = 15'h0456;
    localparam logic [14:0] OFS_CONVERTER_RES     = 15'h0457;
    localparam logic [14:0] OFS_SUBCLASS_WIDTH    = 15'h0458;
    localparam logic [14:0] OFS_VERSION_SPF       = 15'h0459;
    localparam logic [14:0] OFS_HIGH_DENSITY      = 15'h045A;
    localparam logic [14:0] OFS_LANE0_CHECKSUM    = 15'h045D;
    localparam logic [14:0] OFS_LANE_DESKEW       = 15'h046C;
    localparam logic [14:0] OFS_FRAME_OCTETS_CPY  = 15'h0476;
    localparam logic [14:0] OFS_LANE_ENABLE       = 15'h047D;

    // field positions
    localparam int LINK_BANK_SELECT_BIT = 2;
    localparam int TWO_LINK_MODE_BIT    = 3;
    localparam int FRAME_SUM_METHOD_BIT = 6;
    localparam int CDR_HALF_RATE_BIT    = 5;
    localparam int CDR_OVERSAMPLE_BIT   = 1;
    localparam int PLL_DIVIDE_LSB       = 0;
    localparam int PLL_CFG_ONE_BIT      = 2;
    localparam int EQ_SELECT_LSB        = 6;
    localparam int LANE_COUNT_LSB       = 0;
    localparam int SCRAMBLE_BIT         = 7;
    localparam int VERSION_LSB          = 5;
    localparam int LOCK_BIT             = 0;

    // values
    localparam logic [7:0] POWER_UP_VAL  = 8'h00;
    localparam logic [7:0] CDR_RUN_VAL   = 8'h01;
    localparam logic [7:0] PLL_START_VAL = 8'h01;
    localparam logic [2:0] VERSION_B     = 3'h1;
    localparam logic [2:0] VERSION_A     = 3'h0;

    // reset values
    localparam logic [7:0] RST_POWER = 8'h01;
    localparam logic [7:0] RST_EQ    = 8'h22;
    localparam logic [7:0] RST_OTHER = 8'h00;

    // host serial clock half period in CLK cycles
    localparam int SCLK_HALF_CYC = 8;
endpackage

// file: core/srlsr_spi_if.sv
`timescale 1ns/1ns
// serial control port between the configuring host and the register bank
interface srlsr_spi_if;
    logic csb_n;     // frame select, low active
    logic sclk;      // serial clock from host
    logic sdi;       // host to device data
    logic sdo;       // device to host data
    logic sdo_oe;    // device drives sdo
    logic sdo_line;  // resolved line level seen by host

    // undriven line reads low, no pull modelled
    assign sdo_line = sdo_oe ? sdo : 1'b0;

    modport dev (input csb_n, input sclk, input sdi, output sdo, output sdo_oe);
    modport host (output csb_n, output sclk, output sdi, input sdo_line);
endinterface

// file: core/srlsr_dev.sv
`timescale 1ns/1ns
module srlsr_dev (
    input  wire logic                    CLK,          // 20 MHz clock
    input  wire logic                    SRST,         // sync reset, high
    srlsr_spi_if.dev                     SPI,          // serial control port
    input  wire logic                    PLL_LOCK,     // raw serdes pll lock pin
    input  wire logic [15:0]             RX_DID,       // received device id, link1:link0
    input  wire logic [15:0]             RX_BID,       // received bank id
    input  wire logic [15:0]             RX_LID,       // received lane id
    output logic                         IF_POWERED,   // serial rx interface powered
    output logic [7:0]                   IDLE_LANES,   // unused lane mask
    output logic                         CDR_IN_RESET, // clock_recovery held in reset
    output logic                         CDR_HALF_RATE,// half-rate sampling
    output logic                         CDR_OVERSAMPLE,// oversample select
    output logic                         PLL_RUN,      // serdes pll started
    output logic [1:0]                   PLL_DIVIDE,   // serdes_pll_divide
    output logic [1:0]                   EQ_SELECT,    // equaliser_select
    output logic                         TWO_LINK,     // two_link_mode
    output logic                         SUM_METHOD,   // frame_sum_method
    output logic [15:0]                  LANE_EN,      // active lanes per link
    output logic [11:0]                  LANE_COUNT,   // lanes per link, true count
    output logic [1:0]                   MODE_B,       // link runs B protocol
    output logic [1:0]                   MODE_A,       // link runs A protocol
    output logic [1:0]                   SCRAMBLE,     // scrambling per link
    output logic [1:0]                   IDENT_MATCH   // ids equal programmed ones
);
    // shared register slots
    localparam logic [3:0] SH_POWER = 4'h0, SH_IDLE = 4'h1, SH_CDRRST = 4'h2, SH_CDRCFG = 4'h3;
    localparam logic [3:0] SH_EQ = 4'h4, SH_PLLEN = 4'h5, SH_SERDES_PLL_DIVIDE = 4'h6, SH_TUNEA = 4'h7;
    localparam logic [3:0] SH_TERMAL = 4'h8, SH_TERMAH = 4'h9, SH_TUNEB = 4'hA, SH_TERMBL = 4'hB;
    localparam logic [3:0] SH_TERMBH = 4'hC, SH_LINKCTL = 4'hD, SH_PORTCFG = 4'hE;
    // banked register slots
    localparam logic [3:0] BK_DID = 4'h0, BK_BID = 4'h1, BK_LID = 4'h2, BK_SCRL = 4'h3;
    localparam logic [3:0] BK_F = 4'h4, BK_K = 4'h5, BK_M = 4'h6, BK_N = 4'h7, BK_SUBC = 4'h8;
    localparam logic [3:0] BK_VER = 4'h9, BK_HD = 4'hA, BK_CSUM = 4'hB, BK_DESK = 4'hC;
    localparam logic [3:0] BK_FCPY = 4'hD, BK_LANEEN = 4'hE;

    logic [7:0]  sh_ff [0:15];
    logic [7:0]  bk_ff [0:1][0:15];
    logic        csb_s1_ff, csb_s2_ff;
    logic        sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
    logic        sdi_s1_ff, sdi_s2_ff;
    logic        lock_s1_ff, lock_s2_ff;
    logic [4:0]  cnt_ff;
    logic [22:0] shift_ff;
    logic [15:0] hdr_ff;
    logic [7:0]  out_ff;
    logic        oe_ff;
    logic        rise, fall;
    logic [14:0] nxt_addr;
    logic [6:0]  hit;
    logic [6:0]  wr_hit;
    logic [7:0]  rdata;
    logic        sel;
    logic        pll_run;

    // decode: {hit, read_only, banked, slot}
    function automatic logic [6:0] decode(input logic [14:0] a);
        case (a)
            srlsr_pkg::OFS_SERIAL_IF_POWER:   decode = {3'b100, SH_POWER};
            srlsr_pkg::OFS_UNUSED_LANE_MASK:  decode = {3'b100, SH_IDLE};
            srlsr_pkg::OFS_CDR_RESET_CTRL:    decode = {3'b100, SH_CDRRST};
            srlsr_pkg::OFS_CDR_RATE_CONFIG:   decode = {3'b100, SH_CDRCFG};
            srlsr_pkg::OFS_EQUALISER_CONFIG:  decode = {3'b100, SH_EQ};
            srlsr_pkg::OFS_SERDES_PLL_ENABLE: decode = {3'b100, SH_PLLEN};
            srlsr_pkg::OFS_SERDES_PLL_LOCK:   decode = {3'b110, 4'hF};
            srlsr_pkg::OFS_SERDES_PLL_DIV:    decode = {3'b100, SH_SERDES_PLL_DIVIDE};
            srlsr_pkg::OFS_PHY_AUTOTUNE_A:    decode = {3'b100, SH_TUNEA};
            srlsr_pkg::OFS_TERM_A_LOW:        decode = {3'b100, SH_TERMAL};
            srlsr_pkg::OFS_TERM_A_HIGH:       decode = {3'b100, SH_TERMAH};
            srlsr_pkg::OFS_PHY_AUTOTUNE_B:    decode = {3'b100, SH_TUNEB};
            srlsr_pkg::OFS_TERM_B_LOW:        decode = {3'b100, SH_TERMBL};
            srlsr_pkg::OFS_TERM_B_HIGH:       decode = {3'b100, SH_TERMBH};
            srlsr_pkg::OFS_LINK_CONTROL:      decode = {3'b100, SH_LINKCTL};
            srlsr_pkg::OFS_SERDES_PORT_CFG:   decode = {3'b100, SH_PORTCFG};
            srlsr_pkg::OFS_DEVICE_IDENT:      decode = {3'b101, BK_DID};
            srlsr_pkg::OFS_BANK_IDENT:        decode = {3'b101, BK_BID};
            srlsr_pkg::OFS_LANE_IDENT:        decode = {3'b101, BK_LID};
            srlsr_pkg::OFS_SCRAMBLE_LANES:    decode = {3'b101, BK_SCRL};
            srlsr_pkg::OFS_OCTETS_PER_FRAME:  decode = {3'b101, BK_F};
            srlsr_pkg::OFS_FRAMES_PER_MF:     decode = {3'b101, BK_K};
            srlsr_pkg::OFS_CONVERTER_COUNT:   decode = {3'b101, BK_M};
            srlsr_pkg::OFS_CONVERTER_RES:     decode = {3'b101, BK_N};
            srlsr_pkg::OFS_SUBCLASS_WIDTH:    decode = {3'b101, BK_SUBC};
            srlsr_pkg::OFS_VERSION_SPF:       decode = {3'b101, BK_VER};
            srlsr_pkg::OFS_HIGH_DENSITY:      decode = {3'b101, BK_HD};
            srlsr_pkg::OFS_LANE0_CHECKSUM:    decode = {3'b101, BK_CSUM};
            srlsr_pkg::OFS_LANE_DESKEW:       decode = {3'b101, BK_DESK};
            srlsr_pkg::OFS_FRAME_OCTETS_CPY:  decode = {3'b101, BK_FCPY};
            srlsr_pkg::OFS_LANE_ENABLE:       decode = {3'b101, BK_LANEEN};
            default:                          decode = 7'h00; // unmapped
        endcase
    endfunction

    // pin synchronisers; the second stage feeds logic, and sclk keeps a third stage for edge detection
    always_ff @(posedge CLK)
    begin
        csb_s1_ff  <= SPI.csb_n;
        csb_s2_ff  <= csb_s1_ff;
        sclk_s1_ff <= SPI.sclk;
        sclk_s2_ff <= sclk_s1_ff;
        sclk_s3_ff <= sclk_s2_ff;
        sdi_s1_ff  <= SPI.sdi;
        sdi_s2_ff  <= sdi_s1_ff;
        lock_s1_ff <= PLL_LOCK;
        lock_s2_ff <= lock_s1_ff;
    end

    assign rise = sclk_s2_ff & ~sclk_s3_ff;
    assign fall = ~sclk_s2_ff & sclk_s3_ff;
    // the link control register itself is shared so the select never banks itself away
    assign sel      = sh_ff[SH_LINKCTL][srlsr_pkg::LINK_BANK_SELECT_BIT];
    // bit 2 of the divider must be one, otherwise the pll is kept off
    assign pll_run  = (sh_ff[SH_PLLEN] == srlsr_pkg::PLL_START_VAL)
                      & sh_ff[SH_SERDES_PLL_DIVIDE][srlsr_pkg::PLL_CFG_ONE_BIT];
    assign nxt_addr = {shift_ff[13:0], sdi_s2_ff};
    assign hit      = decode(nxt_addr);
    assign wr_hit   = decode(hdr_ff[14:0]);

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rdata = 8'h00;
        if (hit[6] && hit[5])
            rdata = {7'h00, lock_s2_ff & pll_run};
        else if (hit[6] && hit[4])
            rdata = bk_ff[sel][hit[3:0]];
        else if (hit[6])
            rdata = sh_ff[hit[3:0]];
    end

    // bit counter; a raised select aborts the frame
    always_ff @(posedge CLK)
    begin
        if (SRST || csb_s2_ff)
            cnt_ff <= 5'h00;
        else if (rise && cnt_ff != 5'(srlsr_pkg::FRAME_BITS))
            cnt_ff <= cnt_ff + 5'h01;
    end

    // input shifter and latched instruction
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            shift_ff <= 23'h000000;
            hdr_ff   <= 16'h0000;
        end
        else if (rise)
        begin
            shift_ff <= {shift_ff[21:0], sdi_s2_ff};
            if (cnt_ff == 5'(srlsr_pkg::INSTR_BITS - 1))
                hdr_ff <= {shift_ff[14:0], sdi_s2_ff};
        end
    end

    // read data goes out msb first, changing on falling edges
    always_ff @(posedge CLK)
    begin
        if (SRST || csb_s2_ff)
        begin
            out_ff <= 8'h00;
            oe_ff  <= 1'b0;
        end
        else if (rise && cnt_ff == 5'(srlsr_pkg::INSTR_BITS - 1))
        begin
            out_ff <= rdata;
            oe_ff  <= shift_ff[14];
        end
        else if (fall && cnt_ff > 5'(srlsr_pkg::INSTR_BITS))
            out_ff <= {out_ff[6:0], 1'b0};
    end

    assign SPI.sdo    = out_ff[7];
    assign SPI.sdo_oe = oe_ff;

    // register writes commit on the last data bit; read-only and unmapped writes drop
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            for (int i = 0; i < 16; i++)
            begin
                sh_ff[i]    <= srlsr_pkg::RST_OTHER;
                bk_ff[0][i] <= srlsr_pkg::RST_OTHER;
                bk_ff[1][i] <= srlsr_pkg::RST_OTHER;
            end
            sh_ff[SH_POWER] <= srlsr_pkg::RST_POWER;
            sh_ff[SH_EQ]    <= srlsr_pkg::RST_EQ;
        end
        else if (rise && cnt_ff == 5'(srlsr_pkg::FRAME_BITS - 1) && !hdr_ff[srlsr_pkg::RW_BIT]
                 && wr_hit[6] && !wr_hit[5])
        begin
            if (wr_hit[4])
                bk_ff[sel][wr_hit[3:0]] <= {shift_ff[6:0], sdi_s2_ff};
            else
                sh_ff[wr_hit[3:0]] <= {shift_ff[6:0], sdi_s2_ff};
        end
    end

    // shared physical layer controls, registered
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            IF_POWERED     <= 1'b0;
            IDLE_LANES     <= 8'h00;
            CDR_IN_RESET   <= 1'b1;
            CDR_HALF_RATE  <= 1'b0;
            CDR_OVERSAMPLE <= 1'b0;
            PLL_RUN        <= 1'b0;
            PLL_DIVIDE     <= 2'h0;
            EQ_SELECT      <= 2'h0;
            TWO_LINK       <= 1'b0;
            SUM_METHOD     <= 1'b0;
        end
        else
        begin
            IF_POWERED     <= sh_ff[SH_POWER] == srlsr_pkg::POWER_UP_VAL;
            IDLE_LANES     <= sh_ff[SH_IDLE];
            // any value other than the run code keeps the recovery loop in reset
            CDR_IN_RESET   <= sh_ff[SH_CDRRST] != srlsr_pkg::CDR_RUN_VAL;
            CDR_HALF_RATE  <= sh_ff[SH_CDRCFG][srlsr_pkg::CDR_HALF_RATE_BIT];
            CDR_OVERSAMPLE <= sh_ff[SH_CDRCFG][srlsr_pkg::CDR_OVERSAMPLE_BIT];
            PLL_RUN        <= pll_run;
            PLL_DIVIDE     <= sh_ff[SH_SERDES_PLL_DIVIDE][srlsr_pkg::PLL_DIVIDE_LSB +: 2];
            EQ_SELECT      <= sh_ff[SH_EQ][srlsr_pkg::EQ_SELECT_LSB +: 2];
            TWO_LINK       <= sh_ff[SH_LINKCTL][srlsr_pkg::TWO_LINK_MODE_BIT];
            SUM_METHOD     <= sh_ff[SH_LINKCTL][srlsr_pkg::FRAME_SUM_METHOD_BIT];
        end
    end

    // per-link transport settings
    for (genvar l = 0; l < srlsr_pkg::LINKS; l++)
    begin : g_link
        always_ff @(posedge CLK)
        begin
            if (SRST)
            begin
                LANE_EN[l*8 +: 8]    <= 8'h00;
                LANE_COUNT[l*6 +: 6] <= 6'h00;
                MODE_B[l]            <= 1'b0;
                MODE_A[l]            <= 1'b0;
                SCRAMBLE[l]          <= 1'b0;
                IDENT_MATCH[l]       <= 1'b0;
            end
            else
            begin
                // idle lanes stay off even if enabled in the mask
                LANE_EN[l*8 +: 8]    <= bk_ff[l][BK_LANEEN] & ~sh_ff[SH_IDLE];
                LANE_COUNT[l*6 +: 6] <= {1'b0, bk_ff[l][BK_SCRL][srlsr_pkg::LANE_COUNT_LSB +: 5]} + 6'h01;
                MODE_B[l]            <= bk_ff[l][BK_VER][srlsr_pkg::VERSION_LSB +: 3] == srlsr_pkg::VERSION_B;
                MODE_A[l]            <= bk_ff[l][BK_VER][srlsr_pkg::VERSION_LSB +: 3] == srlsr_pkg::VERSION_A;
                SCRAMBLE[l]          <= bk_ff[l][BK_SCRL][srlsr_pkg::SCRAMBLE_BIT];
                IDENT_MATCH[l]       <= bk_ff[l][BK_DID] == RX_DID[l*8 +: 8]
                                        && bk_ff[l][BK_BID] == RX_BID[l*8 +: 8]
                                        && bk_ff[l][BK_LID] == RX_LID[l*8 +: 8];
            end
        end
    end
endmodule // srlsr_dev

// file: core/srlsr_host.sv
`timescale 1ns/1ns
module srlsr_host #(
    parameter int HALF_CYC = srlsr_pkg::SCLK_HALF_CYC // sclk half period in CLK cycles
) (
    input  wire logic        CLK,       // 20 MHz clock
    input  wire logic        SRST,      // sync reset, high
    srlsr_spi_if.host        SPI,       // serial control port
    input  wire logic        CMD_VALID, // command offered
    output logic             CMD_READY, // host idle, command taken
    input  wire logic        CMD_WRITE, // 1 write, 0 read
    input  wire logic [14:0] CMD_ADDR,  // register offset
    input  wire logic [7:0]  CMD_WDATA, // write byte
    output logic             RSP_VALID, // frame finished, one cycle
    output logic [7:0]       RSP_RDATA  // byte read back
);
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} srlsr_hst_e;

    srlsr_hst_e  state_ff;
    logic [7:0]  half_ff;
    logic [4:0]  bits_ff;
    logic [23:0] tx_ff;
    logic [7:0]  rx_ff;
    logic        sclk_ff;
    logic        csb_ff;
    logic        sdo_s1_ff, sdo_s2_ff;
    logic        tick;

    assign tick      = half_ff == 8'(HALF_CYC - 1);
    assign CMD_READY = state_ff == ST_IDLE;
    assign SPI.csb_n = csb_ff;
    assign SPI.sclk  = sclk_ff;
    assign SPI.sdi   = tx_ff[23];

    // return data is a pin: two stages before sampling
    always_ff @(posedge CLK)
    begin
        sdo_s1_ff <= SPI.sdo_line;
        sdo_s2_ff <= sdo_s1_ff;
    end

    // half-period timer, restarted at each frame
    always_ff @(posedge CLK)
    begin
        if (SRST || state_ff == ST_IDLE || tick)
            half_ff <= 8'h00;
        else
            half_ff <= half_ff + 8'h01;
    end

    // frame sequencer; the gap keeps select high long enough for the device synchroniser
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_ff  <= ST_IDLE;
            csb_ff    <= 1'b1;
            sclk_ff   <= 1'b0;
            bits_ff   <= 5'h00;
            tx_ff     <= 24'h000000;
            rx_ff     <= 8'h00;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 8'h00;
        end
        else
        begin
            RSP_VALID <= 1'b0;
            unique case (state_ff)
                ST_IDLE:
                    if (CMD_VALID)
                    begin
                        tx_ff    <= {~CMD_WRITE, CMD_ADDR, CMD_WDATA};
                        csb_ff   <= 1'b0;
                        bits_ff  <= 5'h00;
                        state_ff <= ST_SHIFT;
                    end
                ST_SHIFT:
                    if (tick && !sclk_ff)
                    begin
                        sclk_ff <= 1'b1;
                        rx_ff   <= {rx_ff[6:0], sdo_s2_ff};
                    end
                    else if (tick)
                    begin
                        sclk_ff <= 1'b0;
                        tx_ff   <= {tx_ff[22:0], 1'b0};
                        bits_ff <= bits_ff + 5'h01;
                        if (bits_ff == 5'(srlsr_pkg::FRAME_BITS - 1))
                        begin
                            csb_ff   <= 1'b1;
                            state_ff <= ST_GAP;
                        end
                    end
                ST_GAP:
                    if (tick)
                    begin
                        RSP_VALID <= 1'b1;
                        RSP_RDATA <= rx_ff;
                        state_ff  <= ST_IDLE;
                    end
            endcase
        end
    end
endmodule // srlsr_host

// file: dv/srlsr_assertions.sv
`timescale 1ns/1ns
module srlsr_assertions (
    input wire logic        CLK,          // clock
    input wire logic        SRST,         // sync reset
    input wire logic        csb_n,        // frame select
    input wire logic        sdo_oe,       // sdo drive
    input wire logic        IF_POWERED,   // powered
    input wire logic        CDR_IN_RESET, // recovery reset
    input wire logic        PLL_RUN,      // pll run
    input wire logic [7:0]  IDLE_LANES,   // idle lanes
    input wire logic [15:0] LANE_EN,      // lane enables
    input wire logic [11:0] LANE_COUNT,   // lane counts
    input wire logic [1:0]  MODE_B,       // version b
    input wire logic [1:0]  MODE_A        // version a
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // settings move only when a frame commits, so a change between frames is a stray update
    sequence s_idle; csb_n [*6]; endsequence
    a_sdo_released: assert property (s_idle |-> !sdo_oe) else $error("sdo driven between frames");
    a_sdo_drop_bound: assert property ($rose(csb_n) |-> ##[1:6] !sdo_oe) else $error("sdo held");
    a_oe_in_frame: assert property ($rose(sdo_oe) |-> !csb_n) else $error("sdo outside frame");
    a_power_on_write: assert property ($changed(IF_POWERED) |-> !csb_n) else $error("power moved");
    a_cdr_on_write: assert property ($changed(CDR_IN_RESET) |-> !csb_n) else $error("cdr reset moved");
    a_pll_on_write: assert property ($changed(PLL_RUN) |-> !csb_n) else $error("pll run moved");
    a_lane_gate: assert property (((LANE_EN[7:0] | LANE_EN[15:8]) & IDLE_LANES) == 8'h00)
        else $error("idle lane enabled");
    a_version_excl: assert property ((MODE_A & MODE_B) == 2'b00) else $error("two versions");
    a_count_minus_one: assert property (!$past(SRST) |-> LANE_COUNT[5:0] != 6'h00 && LANE_COUNT[11:6] != 6'h00)
        else $error("lane count zero");
endmodule // srlsr_assertions

// file: dv/test_serial_rx_link_setup_regs.sv
`timescale 1ns/1ns
module test_serial_rx_link_setup_regs;
    logic        clk, srst, pll_lock, cmd_valid, cmd_ready, cmd_write, rsp_valid; // bench controls
    logic        if_pwr, cdr_rst, cdr_half, cdr_ovs, pll_run, two_link, sum_meth; // device levels
    logic [1:0]  pll_div, eq_sel, mode_b, mode_a, scramble, id_match;             // device fields
    logic [15:0] rx_did, rx_bid, rx_lid, lane_en;                                 // ids and lanes
    logic [14:0] cmd_addr;                                                        // register offset
    logic [11:0] lane_cnt;                                                        // lane counts
    logic [7:0]  cmd_wdata, rsp_rdata, idle_lanes, idle, v;                       // bytes
    logic [7:0]  device_ident_cfg [2], bank_ident_cfg [2], lane_ident_cfg [2], lc [2], mask [2];                     // per-link picks
    int          n_mismatch, check_count, seed;                                   // tallies
    srlsr_spi_if spi ();
    srlsr_dev i_srlsr_dev (.CLK(clk), .SRST(srst), .SPI(spi), .PLL_LOCK(pll_lock), .RX_DID(rx_did),
        .RX_BID(rx_bid), .RX_LID(rx_lid), .IF_POWERED(if_pwr), .IDLE_LANES(idle_lanes), .CDR_IN_RESET(cdr_rst),
        .CDR_HALF_RATE(cdr_half), .CDR_OVERSAMPLE(cdr_ovs), .PLL_RUN(pll_run), .PLL_DIVIDE(pll_div),
        .EQ_SELECT(eq_sel), .TWO_LINK(two_link), .SUM_METHOD(sum_meth), .LANE_EN(lane_en),
        .LANE_COUNT(lane_cnt), .MODE_B(mode_b), .MODE_A(mode_a), .SCRAMBLE(scramble), .IDENT_MATCH(id_match));
    srlsr_host i_srlsr_host (.CLK(clk), .SRST(srst), .SPI(spi), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
        .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid),
        .RSP_RDATA(rsp_rdata));
    srlsr_assertions i_srlsr_assertions (.CLK(clk), .SRST(srst), .csb_n(spi.csb_n), .sdo_oe(spi.sdo_oe),
        .IF_POWERED(if_pwr), .CDR_IN_RESET(cdr_rst), .PLL_RUN(pll_run), .IDLE_LANES(idle_lanes),
        .LANE_EN(lane_en), .LANE_COUNT(lane_cnt), .MODE_B(mode_b), .MODE_A(mode_a));
    always #25 clk = ~clk;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one register per frame; the next command waits for the response pulse
    task automatic xfer(input logic [14:0] a, input logic [7:0] d, input logic wr = 1'b1);
        int n;
        @(posedge clk);
        #5;
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, wr, a, d};
        // ready and the response pulse are looked at off the edge, where they are settled
        while (cmd_ready !== 1'b1)
        begin
            @(posedge clk);
            #5;
        end
        @(posedge clk);
        #5;
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 1000)
        begin
            @(posedge clk);
            #5;
            n++;
        end
        if (n >= 1000)
            chk("response", 16'h0001, 16'h0000);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] exp);
        xfer(a, 8'h00, 1'b0);
        chk("register", {8'h00, exp}, {8'h00, rsp_rdata});
    endtask
    function automatic logic [5:0] lanes_of(input logic [7:0] r);
        return {1'b0, r[4:0]} + 6'h01;
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // a whole run is about thirty frames of four hundred cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        seed = 32'h666f6869;
        {clk, srst, pll_lock, rx_did, rx_bid, rx_lid} = {2'b01, 1'b0, 48'h0};
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = '0;
        repeat (5) @(posedge clk);
        #5;
        srst = 1'b0;
        repeat (3) @(posedge clk);
        rd(15'h0200, 8'h01);
        rd(15'h0206, 8'h00);
        rd(15'h7FFF, 8'h00);
        rd(15'h0268, 8'h22);
        chk("power cdr", 16'h0001, {14'h0, if_pwr, cdr_rst});
        $display("test reset done");
        xfer(15'h0200, 8'h00);
        v = $random(seed);
        xfer(15'h0230, v);
        xfer(15'h0206, 8'h01);
        chk("power cdr rate", {12'h0, 2'b10, v[5], v[1]}, {12'h0, if_pwr, cdr_rst, cdr_half, cdr_ovs});
        xfer(15'h0289, {6'h01, v[3:2]});
        xfer(15'h0280, 8'h01);
        chk("pll", {13'h0, 1'b1, v[3:2]}, {13'h0, pll_run, pll_div});
        xfer(15'h0268, {v[7:6], 6'h22});
        chk("equaliser", {14'h0, v[7:6]}, {14'h0, eq_sel});
        pll_lock = 1'b1;
        xfer(15'h0281, 8'h00); // read-only place keeps its lock view
        rd(15'h0281, 8'h01);
        $display("test phy done");
        idle = $random(seed);
        xfer(15'h0201, idle);
        for (int l = 0; l < 2; l++)
        begin
            {device_ident_cfg[l], bank_ident_cfg[l], lane_ident_cfg[l], lc[l]} = $random(seed);
            mask[l] = $random(seed);
            lc[1] = 8'h9F; // widest lane count with scrambling on
            xfer(15'h0300, l ? 8'h0C : 8'h08);
            xfer(15'h0450, device_ident_cfg[l]);
            xfer(15'h0451, bank_ident_cfg[l]);
            xfer(15'h0452, lane_ident_cfg[l]);
            xfer(15'h0453, lc[l]);
            xfer(15'h0459, {l ? 3'h0 : 3'h1, lc[l][4:0]});
            xfer(15'h047D, mask[l]);
        end
        {rx_did, rx_bid, rx_lid} = {device_ident_cfg[1], device_ident_cfg[0], bank_ident_cfg[1], bank_ident_cfg[0], lane_ident_cfg[1] ^ 8'h01, lane_ident_cfg[0]};
        repeat (3) @(posedge clk);
        chk("ident", 16'h0001, {14'h0, id_match});
        rx_lid = {lane_ident_cfg[1], lane_ident_cfg[0]};
        repeat (3) @(posedge clk);
        chk("ident", 16'h0003, {14'h0, id_match});
        chk("lane count", {4'h0, lanes_of(lc[1]), lanes_of(lc[0])}, {4'h0, lane_cnt});
        chk("version", {11'h0, 1'b1, 4'h6}, {11'h0, two_link, mode_b, mode_a});
        chk("lane enable", {mask[1] & ~idle, mask[0] & ~idle}, lane_en);
        chk("idle lanes", {8'h0, idle}, {8'h0, idle_lanes});
        chk("scramble", {14'h0, lc[1][7], lc[0][7]}, {14'h0, scramble});
        rd(15'h0450, device_ident_cfg[1]);
        xfer(15'h0300, 8'h48);
        rd(15'h0450, device_ident_cfg[0]);
        chk("sum method", 16'h0001, {15'h0, sum_meth});
        rd(15'h0201, idle);
        xfer(15'h0459, 8'hE0); // unknown version code
        chk("version", 16'h0002, {12'h0, mode_b, mode_a});
        $display("test links done");
        end_sim();
    end
endmodule // test_serial_rx_link_setup_regs
